// ===== core/msp_pkg.sv
// Shared constants for the media serial pin-mode block
package msp_pkg;
	// ========================================
	// Widths
	localparam int BYTE_W = 8;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	// ========================================
	// Reset values
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic PIN_RST = 1'b0;
	localparam logic OE_RST = 1'b0;
	// ========================================
	// Link clock figures, for reference only: the system clock must run
	// well above twice the link clock for edge detection to hold
	localparam int LINK_CLK_NOM_KHZ = 49152;
	localparam int FRAME_RATE_KHZ = 48;
endpackage : msp_pkg

// ===== core/msp_lane.sv
// One serial lane: byte serialiser and deserialiser on link clock ticks
`timescale 1ns/1ps
`default_nettype none
module msp_lane (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic rise_tick,
	input wire logic fall_tick,
	input wire logic [msp_pkg::BYTE_W-1:0] tx_byte,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic tx_bit,
	output logic tx_active,
	input wire logic rx_enable,
	input wire logic rx_bit,
	output logic [msp_pkg::BYTE_W-1:0] rx_byte,
	output logic rx_valid
);
	// ========================================
	// Transmit
	logic pend;
	logic [msp_pkg::BYTE_W-1:0] tx_sh;
	logic [msp_pkg::CNT_W-1:0] tx_cnt;
	logic next_pend;
	logic next_active;
	logic [msp_pkg::BYTE_W-1:0] next_tx_sh;
	logic [msp_pkg::CNT_W-1:0] next_tx_cnt;
	logic next_bit;
	wire take = tx_valid && tx_ready;
	wire last = (tx_cnt == msp_pkg::CNT_ZERO);

	always_comb begin
		next_pend = pend;
		next_active = tx_active;
		next_tx_sh = tx_sh;
		next_tx_cnt = tx_cnt;
		next_bit = tx_bit;
		if (take) begin
			next_pend = 1'b1;
			next_tx_sh = tx_byte;
		end else if (pend && fall_tick) begin
			// Bits change on the falling link edge, MSB first
			next_pend = 1'b0;
			next_active = 1'b1;
			next_bit = tx_sh[msp_pkg::BYTE_W-1];
			next_tx_sh = {tx_sh[msp_pkg::BYTE_W-2:0], 1'b0};
			next_tx_cnt = msp_pkg::LAST_BIT;
		end else if (tx_active && fall_tick) begin
			if (last) begin
				next_active = 1'b0;
				next_bit = msp_pkg::PIN_RST;
			end else begin
				next_bit = tx_sh[msp_pkg::BYTE_W-1];
				next_tx_sh = {tx_sh[msp_pkg::BYTE_W-2:0], 1'b0};
				next_tx_cnt = tx_cnt - 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pend <= 1'b0;
			tx_active <= 1'b0;
			tx_sh <= msp_pkg::BYTE_RST;
			tx_cnt <= msp_pkg::CNT_ZERO;
			tx_bit <= msp_pkg::PIN_RST;
			tx_ready <= 1'b0;
		end else begin
			pend <= next_pend;
			tx_active <= next_active;
			tx_sh <= next_tx_sh;
			tx_cnt <= next_tx_cnt;
			tx_bit <= next_bit;
			tx_ready <= !next_pend && !next_active;
		end
	end

	// ========================================
	// Receive, sampled on the rising link edge
	logic [msp_pkg::BYTE_W-1:0] rx_sh;
	logic [msp_pkg::CNT_W-1:0] rx_cnt;
	wire rx_full = (rx_cnt == msp_pkg::LAST_BIT);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx_sh <= msp_pkg::BYTE_RST;
			rx_cnt <= msp_pkg::CNT_ZERO;
			rx_byte <= msp_pkg::BYTE_RST;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_enable) begin
				rx_cnt <= msp_pkg::CNT_ZERO;
			end else if (rise_tick) begin
				rx_sh <= {rx_sh[msp_pkg::BYTE_W-2:0], rx_bit};
				rx_cnt <= rx_cnt + 3'h1;
				if (rx_full) begin
					rx_byte <= {rx_sh[msp_pkg::BYTE_W-2:0], rx_bit};
					rx_valid <= 1'b1;
				end
			end
		end
	end
endmodule : msp_lane
`default_nettype wire

// ===== core/msp_media_pins.sv
// Media serial port pin logic for three-pin and five-pin operation
// ========================================
`timescale 1ns/1ps
`default_nettype none
module msp_media_pins (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic five_pin_mode,
	input wire logic media_bus_clock_in,
	input wire logic media_bus_data_line_i,
	output logic media_bus_data_line_o,
	output logic media_bus_data_line_oe,
	input wire logic media_bus_signal_line_i,
	output logic media_bus_signal_line_o,
	output logic media_bus_signal_line_oe,
	output logic media_bus_data_out,
	output logic media_bus_data_out_oe,
	output logic media_bus_signal_out,
	output logic media_bus_signal_out_oe,
	output logic mode_five_pin,
	input wire logic [msp_pkg::BYTE_W-1:0] tx_data_byte,
	input wire logic tx_data_valid,
	output logic tx_data_ready,
	input wire logic [msp_pkg::BYTE_W-1:0] tx_sig_byte,
	input wire logic tx_sig_valid,
	output logic tx_sig_ready,
	input wire logic rx_enable,
	output logic [msp_pkg::BYTE_W-1:0] rx_data_byte,
	output logic rx_data_valid,
	output logic [msp_pkg::BYTE_W-1:0] receive_status_byte,
	output logic rx_sig_valid
);
	// ========================================
	// Synchronisers for every pin input
	logic [1:0] clk_sync;
	logic clk_prev;
	logic [2:0] warm;
	logic [1:0] dat_sync;
	logic [1:0] sig_sync;
	logic [1:0] mode_sync;

	// Link clock, its previous level and a fill marker for edge detection
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			clk_sync <= 2'h0;
			clk_prev <= 1'b0;
			warm <= 3'h0;
		end else begin
			clk_sync <= {clk_sync[0], media_bus_clock_in};
			clk_prev <= clk_sync[1];
			warm <= {warm[1:0], 1'b1};
		end
	end

	// Two-way data pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			dat_sync <= 2'h0;
		end else begin
			dat_sync <= {dat_sync[0], media_bus_data_line_i};
		end
	end

	// Two-way signal pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sig_sync <= 2'h0;
		end else begin
			sig_sync <= {sig_sync[0], media_bus_signal_line_i};
		end
	end

	// Mode pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_sync <= 2'h0;
		end else begin
			mode_sync <= {mode_sync[0], five_pin_mode};
		end
	end

	// ========================================
	// Link clock edges
	// Reset levels in the flops would pass for an edge of a clock that
	// idles high, so edges count only once the chain holds pin values
	wire sync_ready = warm[2];
	// Edges of the controller's clock pace everything on the link
	wire rise_tick = sync_ready && clk_sync[1] && !clk_prev;
	wire fall_tick = sync_ready && !clk_sync[1] && clk_prev;

	// ========================================
	// Mode: taken only while both lanes are idle, so a byte never splits
	// across two pin sets
	logic data_active;
	logic sig_active;
	logic data_bit;
	logic sig_bit;
	wire lanes_idle = !data_active && !sig_active;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_five_pin <= 1'b0;
		end else if (lanes_idle) begin
			mode_five_pin <= mode_sync[1];
		end
	end

	// ========================================
	// Lanes; our own transmission is not received back, and in three-pin
	// mode the line is ours alone while we send
	wire data_rx_en = rx_enable && !data_active;
	wire sig_rx_en = rx_enable && !sig_active;

	msp_lane u_data_lane (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.rise_tick(rise_tick),
		.fall_tick(fall_tick),
		.tx_byte(tx_data_byte),
		.tx_valid(tx_data_valid),
		.tx_ready(tx_data_ready),
		.tx_bit(data_bit),
		.tx_active(data_active),
		.rx_enable(data_rx_en),
		.rx_bit(dat_sync[1]),
		.rx_byte(rx_data_byte),
		.rx_valid(rx_data_valid)
	);

	msp_lane u_sig_lane (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.rise_tick(rise_tick),
		.fall_tick(fall_tick),
		.tx_byte(tx_sig_byte),
		.tx_valid(tx_sig_valid),
		.tx_ready(tx_sig_ready),
		.tx_bit(sig_bit),
		.tx_active(sig_active),
		.rx_enable(sig_rx_en),
		.rx_bit(sig_sync[1]),
		.rx_byte(receive_status_byte),
		.rx_valid(rx_sig_valid)
	);

	// ========================================
	// Pin steering
	wire three_pin = !mode_five_pin;
	wire next_data_line_oe = three_pin && data_active;
	wire next_sig_line_oe = three_pin && sig_active;
	wire next_data_out_oe = mode_five_pin && data_active;
	wire next_sig_out_oe = mode_five_pin && sig_active;

	// Registered so pins change together, one cycle after the lane bit
	// Two-way data pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			media_bus_data_line_o <= msp_pkg::PIN_RST;
		end else begin
			media_bus_data_line_o <= data_bit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			media_bus_data_line_oe <= msp_pkg::OE_RST;
		end else begin
			media_bus_data_line_oe <= next_data_line_oe;
		end
	end

	// Two-way signal pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			media_bus_signal_line_o <= msp_pkg::PIN_RST;
		end else begin
			media_bus_signal_line_o <= sig_bit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			media_bus_signal_line_oe <= msp_pkg::OE_RST;
		end else begin
			media_bus_signal_line_oe <= next_sig_line_oe;
		end
	end

	// Dedicated data out pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			media_bus_data_out <= msp_pkg::PIN_RST;
		end else begin
			media_bus_data_out <= data_bit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			media_bus_data_out_oe <= msp_pkg::OE_RST;
		end else begin
			media_bus_data_out_oe <= next_data_out_oe;
		end
	end

	// Dedicated signal out pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			media_bus_signal_out <= msp_pkg::PIN_RST;
		end else begin
			media_bus_signal_out <= sig_bit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			media_bus_signal_out_oe <= msp_pkg::OE_RST;
		end else begin
			media_bus_signal_out_oe <= next_sig_out_oe;
		end
	end
endmodule : msp_media_pins
`default_nettype wire

// ===== dv/msp_media_pins_chk.sv
// Pin drive checker for the media serial pin block
`timescale 1ns/1ps
`default_nettype none
module msp_chk (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic mode_five_pin,
	input wire logic media_bus_data_line_o,
	input wire logic media_bus_data_line_oe,
	input wire logic media_bus_signal_line_oe,
	input wire logic media_bus_data_out_oe,
	input wire logic media_bus_signal_out_oe,
	input wire logic tx_data_valid,
	input wire logic tx_data_ready,
	input wire logic tx_sig_ready
);
	// ========================================
	// Pin drive rules
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_five_data_in: assert property (mode_five_pin |-> !media_bus_data_line_oe)
		else $error("data line driven in five-pin mode");
	a_five_sig_in: assert property (mode_five_pin |-> !media_bus_signal_line_oe)
		else $error("signal line driven in five-pin mode");
	a_three_dout_off: assert property (!mode_five_pin |-> !media_bus_data_out_oe)
		else $error("data out driven in three-pin mode");
	a_three_sout_off: assert property (!mode_five_pin |-> !media_bus_signal_out_oe)
		else $error("signal out driven in three-pin mode");
	// Ready returns one cycle before the registered enable drops, so look one cycle back
	a_line_busy: assert property (media_bus_data_line_oe |-> !$past(tx_data_ready))
		else $error("data line driven while idle");
	a_sig_busy: assert property ((media_bus_signal_line_oe || media_bus_signal_out_oe)
		|-> !$past(tx_sig_ready))
		else $error("signal pin driven while idle");
	a_take_busy: assert property (tx_data_valid && tx_data_ready |=> !tx_data_ready)
		else $error("byte taken but lane not busy");
	// A bit must outlast many system cycles since it follows the slow link clock
	a_bit_stands: assert property ($rose(media_bus_data_line_oe)
		|=> $stable(media_bus_data_line_o) [*8])
		else $error("first bit did not stand");
endmodule : msp_chk
bind msp_media_pins msp_chk u_chk (.clk_sys, .sys_rst, .mode_five_pin,
	.media_bus_data_line_o, .media_bus_data_line_oe, .media_bus_signal_line_oe,
	.media_bus_data_out_oe, .media_bus_signal_out_oe, .tx_data_valid, .tx_data_ready,
	.tx_sig_ready);
`default_nettype wire

// ===== dv/msp_lane_model.sv
// Far side lane model: sends a byte to the device and captures the device's byte
`timescale 1ns/1ps
`default_nettype none
module msp_lane_model (
	input wire logic lclk,
	input wire logic go,
	input wire logic [7:0] tx_byte,
	input wire logic oe_a,
	input wire logic o_a,
	input wire logic oe_b,
	input wire logic o_b,
	output logic line,
	output logic [7:0] cap_byte,
	output var logic cap_valid = 1'b0
);
	logic drv = 1'b0;
	int n = 0;
	int m = 0;
	// ========================================
	// Line level: no pull, so an idle far side toggles rather than hold a value
	assign line = oe_a ? o_a : drv;
	always @(negedge lclk) begin
		drv <= (go && n < 8) ? tx_byte[7 - n] : ~drv;
		n <= go ? n + 1 : 0;
	end
	// ========================================
	// Capture, MSB first, on rising link edges
	always @(posedge lclk) begin
		cap_valid <= 1'b0;
		if (oe_a || oe_b) begin
			cap_byte <= {cap_byte[6:0], oe_a ? o_a : o_b};
			m <= m + 1;
			cap_valid <= (m == 7);
		end else m <= 0;
	end
endmodule : msp_lane_model
`default_nettype wire

// ===== dv/msp_media_pins_bench.sv
// Self-checking bench for the media serial pin block
`timescale 1ns/1ps
`default_nettype none
module msp_media_pins_bench;
	logic clk_sys = 1'b0, sys_rst = 1'b1, five_pin_mode = 1'b0, lclk = 1'b1, lrun = 1'b0;
	logic go = 1'b0, rx_enable = 1'b0, tdv = 1'b0, tsv = 1'b0;
	logic [7:0] td = 8'h00, ts = 8'h00, rd = 8'h00, rs = 8'h00;
	logic [31:0] seed = 32'hef7c6c8c;
	logic [7:0] qd[$], qs[$], qtd[$], qts[$];
	int n_errors = 0, n_compared = 0, i;
	wire dl_o, dl_oe, sl_o, sl_oe, do_o, do_oe, so_o, so_oe, dl_i, sl_i, mode, tdr, tsr, rdv, rsv;
	wire cdv, csv;
	wire [7:0] rdb, rsb, cd, cs;
	msp_media_pins u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .five_pin_mode(five_pin_mode),
		.media_bus_clock_in(lclk), .media_bus_data_line_i(dl_i), .media_bus_data_line_o(dl_o),
		.media_bus_data_line_oe(dl_oe), .media_bus_signal_line_i(sl_i),
		.media_bus_signal_line_o(sl_o), .media_bus_signal_line_oe(sl_oe),
		.media_bus_data_out(do_o), .media_bus_data_out_oe(do_oe), .media_bus_signal_out(so_o),
		.media_bus_signal_out_oe(so_oe), .mode_five_pin(mode), .tx_data_byte(td),
		.tx_data_valid(tdv), .tx_data_ready(tdr), .tx_sig_byte(ts), .tx_sig_valid(tsv),
		.tx_sig_ready(tsr), .rx_enable(rx_enable), .rx_data_byte(rdb), .rx_data_valid(rdv),
		.receive_status_byte(rsb), .rx_sig_valid(rsv));
	msp_lane_model u_md (.lclk(lclk), .go(go), .tx_byte(rd), .oe_a(dl_oe), .o_a(dl_o),
		.oe_b(do_oe), .o_b(do_o), .line(dl_i), .cap_byte(cd), .cap_valid(cdv));
	msp_lane_model u_ms (.lclk(lclk), .go(go), .tx_byte(rs), .oe_a(sl_oe), .o_a(sl_o),
		.oe_b(so_oe), .o_b(so_o), .line(sl_i), .cap_byte(cs), .cap_valid(csv));
	// ========================================
	// Clocks: the link clock stops high between frames
	initial forever #5 clk_sys = ~clk_sys;
	initial forever #62.5 if (lrun) lclk = ~lclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic frame();
		lrun = 1'b1;
		repeat (10) @(posedge lclk);
		lrun = 1'b0;
	endtask : frame
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// ========================================
	// Watchers
	always @(posedge clk_sys) begin
		if (rdv === 1'b1) cmp("rx_data_byte", qd.pop_front(), rdb);
		if (rsv === 1'b1) cmp("receive_status_byte", qs.pop_front(), rsb);
	end
	always @(posedge cdv) #1 cmp("data byte sent", qtd.pop_front(), cd);
	always @(posedge csv) #1 cmp("signal byte sent", qts.pop_front(), cs);
	always @(posedge cdv) #1 cmp("data out used", {7'h00, five_pin_mode}, {7'h00, do_oe});
	always @(posedge cdv) #1 cmp("data line used", {7'h00, !five_pin_mode}, {7'h00, dl_oe});
	always @(posedge csv) #1 cmp("sig out used", {7'h00, five_pin_mode}, {7'h00, so_oe});
	always @(posedge csv) #1 cmp("sig line used", {7'h00, !five_pin_mode}, {7'h00, sl_oe});
	// ========================================
	// Two rounds in three-pin mode, then two in five-pin mode
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			five_pin_mode <= k[1];
			repeat (8) @(posedge clk_sys);
			cmp("mode_five_pin", {7'h00, k[1]}, {7'h00, mode});
			seed = lfsr(seed);
			{td, ts, rd, rs} <= seed;
			rx_enable <= 1'b1;
			go = 1'b1;
			@(posedge clk_sys);
			qd.push_back(rd);
			qs.push_back(rs);
			frame();
			go = 1'b0;
			@(posedge clk_sys);
			rx_enable <= 1'b0;
			tdv <= 1'b1;
			tsv <= 1'b1;
			for (i = 0; i < 20; i++) begin
				@(posedge clk_sys);
				if (tdr === 1'b1 && tsr === 1'b1) break;
			end
			tdv <= 1'b0;
			tsv <= 1'b0;
			qtd.push_back(td);
			qts.push_back(ts);
			if (i == 20) n_errors++;
			if (i == 20) tally_and_finish();
			frame();
		end
		@(posedge clk_sys);
		cmp("bytes left", 8'h00, 8'(qd.size() + qs.size() + qtd.size() + qts.size()));
		tally_and_finish();
	end
endmodule : msp_media_pins_bench
`default_nettype wire
